// ==== src/jtag_rb_pkg.sv ====
// Constants, step encoding and state record for the shutdown readback JTAG host.
// Assumes a 100 MHz system clock; the test clock is divided down from it.
package jtag_rb_pkg;

  // Timing: the test clock period is built from the system clock period.
  localparam int SYS_PERIOD_NS = 10;
  localparam int TCK_PERIOD_NS = 100;
  localparam int TCK_HALF_CYC_I = TCK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam logic [7:0] TCK_HALF_CYC = TCK_HALF_CYC_I[7:0];
  localparam logic [7:0] TCK_LAST_PH = 8'(2 * TCK_HALF_CYC_I - 1);

  // Instruction codes, six bits, shifted least significant bit first.
  localparam int IR_LEN = 6;
  localparam logic [5:0] SHUTDOWN_INSTR = 6'h0d;
  localparam logic [5:0] CFG_IN_INSTR = 6'h05;
  localparam logic [5:0] CFG_OUT_INSTR = 6'h04;

  // Segment lengths in test clocks.
  localparam logic [31:0] LEN_TLR_ENTRY = 32'h5;
  localparam logic [31:0] LEN_ONE = 32'h1;
  localparam logic [31:0] LEN_TWO = 32'h2;
  localparam logic [31:0] LEN_THREE = 32'h3;
  localparam logic [31:0] LEN_IR = 32'h6;
  localparam logic [31:0] LEN_RTI_WAIT = 32'h18;
  localparam logic [31:0] LEN_PKT_LOW = 32'h10f;
  localparam logic [31:0] LEN_PKT = LEN_PKT_LOW + LEN_ONE;

  // Readback request packet, sent word 0 first, each word MSB first.
  localparam int PKT_WORDS = 17;
  localparam logic [15:0] PKT_ROM [PKT_WORDS] = '{
    16'hffff, 16'hffff, 16'haa99, 16'h5566, 16'h30a1, 16'h0008,
    16'h31a1, 16'h0000, 16'h3022, 16'h0000, 16'h0000, 16'h30a1,
    16'h0004, 16'h4880, 16'h0000, 16'h2000, 16'h2000};

  typedef enum logic [4:0] {
    ST_IDLE, ST_TLR_IN, ST_RTI_IN, ST_SEL_IR1, ST_TO_SIR1, ST_SDN_IR, ST_UPD_IR1,
    ST_RTI_WAIT, ST_SEL_IR2, ST_TO_SIR2, ST_CFGIN_IR, ST_SEL_DR1, ST_TO_SDR1,
    ST_PKT, ST_SEL_IR3, ST_TO_SIR3, ST_CFGOUT_IR, ST_SEL_DR2, ST_TO_SDR2,
    ST_RDBK, ST_SEL_IR4, ST_TO_SIR4, ST_TLR_OUT, ST_DONE
  } step_e;

  typedef struct packed {
    step_e step;
    logic [31:0] idx;
    logic [31:0] rb_len;
    logic [7:0] ph;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo_meta;
    logic tdo_sync;
    logic rb_data;
    logic rb_valid;
    logic busy;
    logic done;
  } host_state_s;

endpackage

// ==== src/jtag_rb_host.sv ====
// Host that drives a device's test access port through a shutdown and frame readback.
// Assumes the device samples mode select and data-in on rising test clock and
// changes data-out on the falling edge; data-out is asynchronous to this clock.
//
// Overview of operation
// - The shutdown instruction 01101 is shifted LSB first and the port then idles 24 clocks.
// - The configuration-input instruction 00101 is shifted LSB first with mode select low.
// - The zero MSB of each instruction goes out with mode select high to leave Shift-IR.
// - After each configuration instruction shift, mode select is high two clocks then low two to reach Shift-DR.
// - The request packet is shifted MSB first with mode select low for 271 clocks.
// - The packet words go out in the fixed order from dummy and sync down to two no-ops.
// - The LSB of the last packet word goes out with mode select high, leaving Shift-DR.
// - From Exit-DR, mode select is high three clocks then low two to reach Shift-IR.
// - The configuration-output instruction 00100 is shifted LSB first, then a zero with exit.
// - Readback clocks with mode select low for one fewer than the readback bit count.
// - The last readback bit is taken on one clock with mode select high.
// - The sequence ends with high three, low two, then high three, leaving the port in Select-DR.
`timescale 1ns/10ps
`default_nettype none

module jtag_rb_host
  import jtag_rb_pkg::*;
(
  // Clock, reset and enable
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // User control
  input wire logic START_I,
  input wire logic [31:0] RB_BITS_I,
  output logic BUSY_O,
  output logic DONE_O,
  // Readback stream
  output logic RB_DATA_O,
  output logic RB_VALID_O,
  // Test access port pins
  output logic TCK_O,
  output logic TMS_O,
  output logic TDI_O,
  input wire logic TDO_I
);
  import jtag_rb_pkg::*;

  // The whole state is one record: the next value is built below and registered once.
  host_state_s q_r;
  host_state_s q_nxt;

  // Order of the port walk; each step is a run of test clocks, with fixed pin levels outside the shift steps.
  function automatic step_e step_after(input step_e s);
    case (s)
      ST_TLR_IN: step_after = ST_RTI_IN;
      ST_RTI_IN: step_after = ST_SEL_IR1;
      ST_SEL_IR1: step_after = ST_TO_SIR1;
      ST_TO_SIR1: step_after = ST_SDN_IR;
      ST_SDN_IR: step_after = ST_UPD_IR1;
      ST_UPD_IR1: step_after = ST_RTI_WAIT;
      ST_RTI_WAIT: step_after = ST_SEL_IR2;
      ST_SEL_IR2: step_after = ST_TO_SIR2;
      ST_TO_SIR2: step_after = ST_CFGIN_IR;
      ST_CFGIN_IR: step_after = ST_SEL_DR1;
      ST_SEL_DR1: step_after = ST_TO_SDR1;
      ST_TO_SDR1: step_after = ST_PKT;
      ST_PKT: step_after = ST_SEL_IR3;
      ST_SEL_IR3: step_after = ST_TO_SIR3;
      ST_TO_SIR3: step_after = ST_CFGOUT_IR;
      ST_CFGOUT_IR: step_after = ST_SEL_DR2;
      ST_SEL_DR2: step_after = ST_TO_SDR2;
      ST_TO_SDR2: step_after = ST_RDBK;
      ST_RDBK: step_after = ST_SEL_IR4;
      ST_SEL_IR4: step_after = ST_TO_SIR4;
      ST_TO_SIR4: step_after = ST_TLR_OUT;
      ST_TLR_OUT: step_after = ST_DONE;
      default: step_after = ST_DONE;
    endcase
  endfunction

  // Test clocks in each step. The readback step takes its length from the start
  // request, so one walk can read any number of bits.
  function automatic logic [31:0] step_len(input step_e s, input logic [31:0] rb_len);
    case (s)
      ST_TLR_IN: step_len = LEN_TLR_ENTRY;
      ST_RTI_IN, ST_UPD_IR1: step_len = LEN_ONE;
      ST_SDN_IR, ST_CFGIN_IR, ST_CFGOUT_IR: step_len = LEN_IR;
      ST_RTI_WAIT: step_len = LEN_RTI_WAIT;
      ST_PKT: step_len = LEN_PKT;
      ST_SEL_IR3, ST_SEL_IR4, ST_TLR_OUT: step_len = LEN_THREE;
      ST_RDBK: step_len = rb_len;
      default: step_len = LEN_TWO;
    endcase
  endfunction

  // Returns {tms, tdi} for bit idx of step s.
  // The last bit of every shift step carries mode select high to leave the shift state.
  function automatic logic [1:0] bit_out(input step_e s, input logic [31:0] idx,
                                         input logic [31:0] rb_len);
    logic last;
    logic [31:0] word;
    logic [3:0] pos;
    last = (idx == step_len(s, rb_len) - LEN_ONE);
    word = idx >> 4;
    pos = 4'hf - idx[3:0];
    case (s)
      ST_TLR_IN, ST_SEL_IR1, ST_UPD_IR1, ST_SEL_IR2,
      ST_SEL_DR1, ST_SEL_IR3, ST_SEL_DR2,
      ST_SEL_IR4, ST_TLR_OUT, ST_DONE: bit_out = 2'h2;
      ST_SDN_IR: bit_out = {last, SHUTDOWN_INSTR[idx[2:0]]};
      ST_CFGIN_IR: bit_out = {last, CFG_IN_INSTR[idx[2:0]]};
      ST_CFGOUT_IR: bit_out = {last, CFG_OUT_INSTR[idx[2:0]]};
      // Word index and bit position walk the packet most significant bit first.
      ST_PKT: bit_out = {last, PKT_ROM[word[4:0]][pos]};
      // Data-in is held low while reading; the device ignores it there.
      ST_RDBK: bit_out = {last, 1'h0};
      default: bit_out = 2'h0;
    endcase
  endfunction

  always_comb begin
    logic [1:0] pins;
    logic [31:0] rb_len;
    step_e nstep;
    logic [31:0] nidx;
    pins = 2'h0;
    rb_len = 32'h0;
    nstep = q_r.step;
    nidx = q_r.idx;
    q_nxt = q_r;
    // With the enable low nothing moves, the valid pulse included, so a pulse is
    // never lost to a stall.
    if (CE_I) begin
      q_nxt.rb_valid = 1'h0;
      // Data-out passes two flops before anything looks at it.
      q_nxt.tdo_meta = TDO_I;
      q_nxt.tdo_sync = q_r.tdo_meta;
      case (q_r.step)
        ST_IDLE, ST_DONE: begin
          if (START_I) begin
            // A zero bit count would leave no clock to exit Shift-DR, so it counts as one.
            rb_len = (RB_BITS_I == 32'h0) ? LEN_ONE : RB_BITS_I;
            pins = bit_out(ST_TLR_IN, 32'h0, rb_len);
            q_nxt.rb_len = rb_len;
            q_nxt.step = ST_TLR_IN;
            q_nxt.idx = 32'h0;
            q_nxt.ph = 8'h0;
            q_nxt.tck = 1'h0;
            q_nxt.tms = pins[1];
            q_nxt.tdi = pins[0];
            q_nxt.busy = 1'h1;
            q_nxt.done = 1'h0;
          end
        end
        default: begin
          // A start request during a walk is ignored without any sign.
          if (q_r.ph == TCK_LAST_PH) begin
            // End of the high phase: data-out was settled since the falling edge before.
            if (q_r.step == ST_RDBK) begin
              q_nxt.rb_data = q_r.tdo_sync;
              q_nxt.rb_valid = 1'h1;
            end
            if (q_r.idx == step_len(q_r.step, q_r.rb_len) - LEN_ONE) begin
              nstep = step_after(q_r.step);
              nidx = 32'h0;
            end else begin
              nidx = q_r.idx + LEN_ONE;
            end
            // Mode select and data-in change only here, with the falling clock, so the
            // device finds them settled for half a period before it samples.
            pins = bit_out(nstep, nidx, q_r.rb_len);
            q_nxt.step = nstep;
            q_nxt.idx = nidx;
            q_nxt.ph = 8'h0;
            q_nxt.tck = 1'h0;
            q_nxt.tms = pins[1];
            q_nxt.tdi = pins[0];
            // The closing steps leave the port in Select-DR, not in reset; the next
            // start walks it to reset first, so nothing depends on where it rests.
            if (nstep == ST_DONE) begin
              q_nxt.busy = 1'h0;
              q_nxt.done = 1'h1;
            end
          end else begin
            // The clock is low for the first half of the phase count and high for the rest.
            q_nxt.ph = q_r.ph + 8'h1;
            q_nxt.tck = ((q_r.ph + 8'h1) >= TCK_HALF_CYC);
          end
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      // Reset parks the pins at their idle levels: clock low, mode select high.
      q_r <= '{
        step: ST_IDLE,
        idx: 32'h0,
        rb_len: LEN_ONE,
        ph: 8'h0,
        tck: 1'h0,
        tms: 1'h1,
        tdi: 1'h0,
        tdo_meta: 1'h0,
        tdo_sync: 1'h0,
        rb_data: 1'h0,
        rb_valid: 1'h0,
        busy: 1'h0,
        done: 1'h0
      };
    end else begin
      q_r <= q_nxt;
    end
  end

  // Every pin and status output is a bare register field, free of glitches.
  assign TCK_O = q_r.tck;
  assign TMS_O = q_r.tms;
  assign TDI_O = q_r.tdi;
  assign RB_DATA_O = q_r.rb_data;
  assign RB_VALID_O = q_r.rb_valid;
  assign BUSY_O = q_r.busy;
  assign DONE_O = q_r.done;

endmodule

`default_nettype wire

// ==== bench/jtag_rb_host_chk.sv ====
// Port assertions for the readback host.
// Assumes it is bound to jtag_rb_host; cycles with CE_I low are not judged.
`timescale 1ns/10ps
`default_nettype none
module jtag_rb_host_chk (
  // Clock and control
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic START_I,
  // Status and pins
  input wire logic BUSY_O,
  input wire logic DONE_O,
  input wire logic RB_VALID_O,
  input wire logic TCK_O,
  input wire logic TMS_O,
  input wire logic TDI_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I || !CE_I);
  property p_tms_hold; $changed(TMS_O) |-> !TCK_O; endproperty
  a_tms_hold: assert property (p_tms_hold) else $error("mode select moved, clock high");
  property p_tdi_hold; $changed(TDI_O) |-> !TCK_O; endproperty
  a_tdi_hold: assert property (p_tdi_hold) else $error("data-in moved, clock high");
  property p_tck_high; $rose(TCK_O) |-> TCK_O [*5] ##1 !TCK_O; endproperty
  a_tck_high: assert property (p_tck_high) else $error("test clock high time wrong");
  property p_vpulse; RB_VALID_O |=> !RB_VALID_O; endproperty
  a_vpulse: assert property (p_vpulse) else $error("readback valid too long");
  property p_vfall; $rose(RB_VALID_O) |-> $fell(TCK_O) && BUSY_O; endproperty
  a_vfall: assert property (p_vfall) else $error("readback valid off clock fall");
  property p_start; START_I && !BUSY_O |=> BUSY_O && !DONE_O; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_done; $fell(BUSY_O) |-> DONE_O; endproperty
  a_done: assert property (p_done) else $error("end without done");
  property p_idle; !BUSY_O |-> !TCK_O && TMS_O && !TDI_O; endproperty
  a_idle: assert property (p_idle) else $error("pins not idle");
endmodule
`default_nettype wire

// ==== bench/jtag_rb_dev.sv ====
// Behavioural device test port holding a frame readback output register.
// Assumes a clean host-made test clock; data-out moves on its falling edge.
`timescale 1ns/10ps
`default_nettype none
module jtag_rb_dev
  import jtag_rb_pkg::*;
#(parameter logic [31:0] RB_PAT = 32'h0)
(
  // Test access port
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o
);
  int t0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
  int t1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
  int st = 0;
  int k = 0;
  logic [5:0] ir_sh = 6'h0;
  logic [5:0] ir = 6'h0;
  logic [1:0] log_q[$];
  initial tdo_o = 1'b0;
  always @(posedge tck_i) begin
    log_q.push_back({tms_i, tdi_i});
    if (st == 11) ir_sh <= {tdi_i, ir_sh[5:1]};
    if (st == 15) ir <= ir_sh;
    st <= tms_i ? t1[st] : t0[st];
  end
  // Outside readback the line toggles so a stale level never passes for data.
  always @(negedge tck_i) begin
    if (st == 3) k <= 0;
    if (st == 4 && ir == CFG_OUT_INSTR) begin
      tdo_o <= RB_PAT[31 - (k % 32)];
      k <= k + 1;
    end else tdo_o <= ~tdo_o;
  end
endmodule
`default_nettype wire

// ==== bench/jtag_rb_host_bench.sv ====
// Self-checking bench for the shutdown readback host.
// Assumes the device model and the checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module jtag_rb_host_bench;
  localparam logic [31:0] PAT = 32'hc3a5_96e1;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic ce = 1'b1;
  logic [31:0] nbits = 32'h0;
  logic busy, done, rb_d, rb_v, tck, tms, tdi, tdo;
  int err_count = 0;
  int checks = 0;
  logic [1:0] exp_q[$];
  logic rb_q[$];
  jtag_rb_host dut (.SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce), .START_I(start),
    .RB_BITS_I(nbits), .BUSY_O(busy), .DONE_O(done), .RB_DATA_O(rb_d), .RB_VALID_O(rb_v),
    .TCK_O(tck), .TMS_O(tms), .TDI_O(tdi), .TDO_I(tdo));
  jtag_rb_dev #(.RB_PAT(PAT)) dev (.tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo));
  initial forever #5 clk = ~clk;
  always @(posedge clk)
    if (rb_v === 1'b1 && ce === 1'b1) rb_q.push_back(rb_d);
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put(input logic m, input logic d, input int n);
    repeat (n) exp_q.push_back({m, d});
  endtask
  task automatic put_ir(input logic [5:0] v);
    for (int i = 0; i < 6; i++) put(i == 5, v[i], 1);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    cyc(6);
    rst = 1'b0;
    check(32'({busy, done, tck, tms, tdi}), 32'h2);
    $display("reset test done");
  endtask
  // Full sequence; start is held while busy to show it is ignored.
  task automatic run_seq(input int n, input bit stall);
    logic [15:0] pkt[17] = '{16'hffff, 16'hffff, 16'haa99, 16'h5566, 16'h30a1, 16'h0008,
      16'h31a1, 16'h0000, 16'h3022, 16'h0000, 16'h0000, 16'h30a1, 16'h0004, 16'h4880,
      16'h0000, 16'h2000, 16'h2000};
    int k;
    int lb;
    int rbb;
    logic [6:0] snap;
    exp_q = {};
    lb = dev.log_q.size();
    rbb = rb_q.size();
    put(1, 0, 5);
    put(0, 0, 1);
    put(1, 0, 2);
    put(0, 0, 2);
    put_ir(6'h0d);
    put(1, 0, 1);
    put(0, 0, 24);
    put(1, 0, 2);
    put(0, 0, 2);
    put_ir(6'h05);
    put(1, 0, 2);
    put(0, 0, 2);
    for (int i = 0; i < 272; i++) put(i == 271, pkt[i / 16][15 - i % 16], 1);
    put(1, 0, 3);
    put(0, 0, 2);
    put_ir(6'h04);
    put(1, 0, 2);
    put(0, 0, 2);
    put(0, 0, n - 1);
    put(1, 0, 4);
    put(0, 0, 2);
    put(1, 0, 3);
    nbits = 32'(n);
    start = 1'b1;
    cyc(40);
    start = 1'b0;
    if (stall) begin
      // Freeze on the edge after a valid pulse rose; the pulse must survive the stall.
      for (k = 0; k < 20000 && rb_v !== 1'b1; k++) cyc(1);
      check(32'(k < 20000), 32'h1);
      ce = 1'b0;
      cyc(1);
      snap = {busy, done, rb_d, rb_v, tck, tms, tdi};
      cyc(20);
      check(32'({busy, done, rb_d, rb_v, tck, tms, tdi}), 32'(snap));
      check(32'(rb_v), 32'h1);
      ce = 1'b1;
    end
    for (k = 0; k < 20000 && done !== 1'b1; k++) cyc(1);
    check(32'(k < 20000), 32'h1);
    if (k == 20000) give_verdict();
    check(32'({busy, done}), 32'h1);
    check(32'(dev.log_q.size() - lb), 32'(exp_q.size()));
    foreach (exp_q[i]) check(32'(dev.log_q[lb + i]), 32'(exp_q[i]));
    check(32'(rb_q.size() - rbb), 32'(n));
    for (int i = 0; i < n; i++) check(32'(rb_q[rbb + i]), 32'(PAT[31 - i % 32]));
    $display("sequence with %0d readback bits done", n);
  endtask
  // A fresh start from done, left in mid-walk for the reset that follows, which must stop it dead.
  task automatic abort_run();
    start = 1'b1;
    cyc(900);
    start = 1'b0;
    check(32'({busy, done}), 32'h2);
    $display("reset in mid-walk test done");
  endtask
  initial begin
    do_reset();
    run_seq(40, 1'b0);
    run_seq(1, 1'b0);
    abort_run();
    do_reset();
    run_seq(33, 1'b1);
    give_verdict();
  end
endmodule
bind jtag_rb_host jtag_rb_host_chk chk (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .CE_I(CE_I),
  .START_I(START_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .RB_VALID_O(RB_VALID_O),
  .TCK_O(TCK_O), .TMS_O(TMS_O), .TDI_O(TDI_O));
`default_nettype wire
